// >>> core/xps_crosspoint.sv
// 64x64 crosspoint switch core with double-buffered routing latches and monitor.
// Assumes pins synchronous to core_clk; master_clk is a sampled level, not a clock.
//
// What this block does
// - Sixty-four inputs, each output own 64:1 selector
// - Committed float bit tristates that output
// - Destination select captured into holding latch
// - Channel address picks which holding latch
// - Load pulse writes addressed holding latch only
// - Commit pulse copies all holding to control
// - Monitor select picks control latch to show
// - Observation only while monitor enable high
// - Monitor bus shows source select and float
// - Monitor path shows selected selector output
// - Mode select high registered, low flow-through
// - Master clock times data, at most 200 MHz; here sampled at the 25 MHz core rate
// - Monitor bus released within 10 ns; here one 40 ns core cycle after enable drops
// - Low six bits binary input number, MSB float
// - Registered mode captures inputs, registers outputs
// - Flow-through ignores master clock
module xps_crosspoint #(
	parameter int DRAIN_DIV = xps_pkg::DRAIN_DIV_DEF,
	parameter int FIFO_DEPTH = xps_pkg::CMD_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic master_clk,
	input wire logic [xps_pkg::N_PORTS-1:0] switch_inputs,
	output logic [xps_pkg::N_PORTS-1:0] switch_outputs,
	output logic [xps_pkg::N_PORTS-1:0] switch_outputs_oe,
	output logic [6:0] monitor_bus,
	output logic monitor_path_out,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int N = xps_pkg::N_PORTS;
	localparam int CW = $bits(xps_pkg::xps_cmd_t);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	localparam int DW = (DRAIN_DIV < 2) ? 1 : $clog2(DRAIN_DIV);

	generate
		if (DRAIN_DIV < 1 || FIFO_DEPTH < 2 || LW > 8) begin : g_bad_param
			$error("xps_crosspoint: unsupported DRAIN_DIV or FIFO_DEPTH");
		end
		if (xps_pkg::MON_RELEASE_CYC < 1) begin : g_bad_release
			$error("xps_crosspoint: monitor release faster than one cycle");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_s1_r;
	logic rst_n;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port

	xps_pkg::xps_ctrl_t ctrl_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_go;
	logic wr_push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [LW-1:0] fifo_level;
	xps_pkg::xps_cmd_t cmd_in;
	xps_pkg::xps_cmd_t cmd_out;

	// Commands need FIFO room; back-pressure holds bvalid and the channel readies
	assign wr_push = (awaddr_r == xps_pkg::OFS_LOAD) || (awaddr_r == xps_pkg::OFS_COMMIT);
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid
		&& (!wr_push || fifo_in_ready);
	assign cmd_in.commit = (awaddr_r == xps_pkg::OFS_COMMIT);
	assign cmd_in.flt = wdata_r[xps_pkg::LOAD_FLOAT_BIT];
	assign cmd_in.dest = wdata_r[xps_pkg::LOAD_DEST_LSB +: xps_pkg::SEL_W];
	assign cmd_in.chan = wdata_r[xps_pkg::LOAD_CHAN_LSB +: xps_pkg::SEL_W];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= xps_pkg::RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_push || awaddr_r == xps_pkg::OFS_CTRL
					|| awaddr_r == xps_pkg::OFS_STATUS) ? xps_pkg::RESP_OKAY
					: xps_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Mode, monitor enable, monitor select and drain pause
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= xps_pkg::CTRL_RESET;
		end else if (wr_go && awaddr_r == xps_pkg::OFS_CTRL) begin
			if (wstrb_r[0]) begin
				ctrl_r.reg_mode <= wdata_r[xps_pkg::CTRL_MODE_BIT];
				ctrl_r.mon_en <= wdata_r[xps_pkg::CTRL_MON_EN_BIT];
				ctrl_r.pause <= wdata_r[xps_pkg::CTRL_PAUSE_BIT];
			end
			if (wstrb_r[1]) begin
				ctrl_r.mon_sel <= wdata_r[xps_pkg::CTRL_MON_SEL_LSB +: xps_pkg::SEL_W];
			end
		end
	end

	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[xps_pkg::STAT_EMPTY_BIT] = !fifo_out_valid;
		status_word[xps_pkg::STAT_FULL_BIT] = !fifo_in_ready;
		status_word[xps_pkg::STAT_LEVEL_LSB +: LW] = fifo_level;
		status_word[xps_pkg::STAT_MON_LSB +: 7] = monitor_bus;
		status_word[xps_pkg::STAT_PATH_BIT] = monitor_path_out;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= xps_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= xps_pkg::RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'h0})
				xps_pkg::OFS_CTRL: s_axi_rdata <= {18'h00000, ctrl_r.mon_sel, 5'h00,
					ctrl_r.pause, ctrl_r.mon_en, ctrl_r.reg_mode};
				xps_pkg::OFS_STATUS: s_axi_rdata <= status_word;
				xps_pkg::OFS_LOAD, xps_pkg::OFS_COMMIT: s_axi_rdata <= 32'h0000_0000;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= xps_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command queue and latch programming

	logic [DW-1:0] div_r;
	logic drain_tick;
	logic pop;

	assign drain_tick = (div_r == DW'(DRAIN_DIV - 1));
	assign pop = drain_tick && fifo_out_valid && !ctrl_r.pause;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
		end else begin
			div_r <= drain_tick ? '0 : div_r + 1'b1;
		end
	end

	xps_fifo #(
		.WIDTH(CW),
		.DEPTH(FIFO_DEPTH)
	) u_cmd_fifo (
		.clk(core_clk),
		.rst_n(rst_n),
		.in_data(cmd_in),
		.in_valid(wr_go && wr_push),
		.in_ready(fifo_in_ready),
		.out_data(cmd_out),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.level(fifo_level)
	);

	// Holding and control latches carry no reset, as on the original part
	xps_pkg::xps_ctl_t hold_r [N];
	xps_pkg::xps_ctl_t ctl_r [N];

	always_ff @(posedge core_clk) begin
		if (pop && !cmd_out.commit) begin
			hold_r[cmd_out.chan] <= '{flt: cmd_out.flt, src: cmd_out.dest};
		end
	end

	always_ff @(posedge core_clk) begin
		if (pop && cmd_out.commit) begin
			ctl_r <= hold_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Switch datapath

	logic mclk_d_r;
	logic mclk_rise;
	logic [N-1:0] in_cap_r;
	logic [N-1:0] src_vec;
	logic out_update;

	// Master clock edges are seen at core rate, so its usable rate is far below 200 MHz
	assign mclk_rise = master_clk && !mclk_d_r;
	assign src_vec = ctrl_r.reg_mode ? in_cap_r : switch_inputs;
	assign out_update = !ctrl_r.reg_mode || mclk_rise;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mclk_d_r <= 1'b0;
			in_cap_r <= '0;
		end else begin
			mclk_d_r <= master_clk;
			if (ctrl_r.reg_mode && mclk_rise) begin
				in_cap_r <= switch_inputs;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			switch_outputs <= '0;
			switch_outputs_oe <= '0;
		end else if (out_update) begin
			for (int i = 0; i < N; i++) begin
				switch_outputs[i] <= src_vec[ctl_r[i].src];
				switch_outputs_oe[i] <= !ctl_r[i].flt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Monitor

	xps_pkg::xps_ctl_t mon_word;
	assign mon_word = ctl_r[ctrl_r.mon_sel];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			monitor_bus <= 7'h00;
			monitor_path_out <= 1'b0;
		end else if (!ctrl_r.mon_en) begin
			monitor_bus <= 7'h00;
			monitor_path_out <= 1'b0;
		end else if (out_update) begin
			monitor_bus <= mon_word;
			monitor_path_out <= src_vec[mon_word.src];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	// Control latches are unknown until the first commit; the flow data and float enable checks wait for it
	logic routed_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			routed_r <= 1'b0;
		end else if (pop && cmd_out.commit) begin
			routed_r <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_flow_data;
		routed_r && !ctrl_r.reg_mode
			|=> switch_outputs[1] == $past(switch_inputs[ctl_r[1].src]);
	endproperty
	a_flow_data: assert property (p_flow_data) else $error("flow data mismatch");

	property p_float_oe;
		routed_r && !ctrl_r.reg_mode |=> switch_outputs_oe[0] == !$past(ctl_r[0].flt);
	endproperty
	a_float_oe: assert property (p_float_oe) else $error("float enable mismatch");

	property p_reg_hold;
		ctrl_r.reg_mode && !mclk_rise && !$rose(ctrl_r.reg_mode) |=> $stable(switch_outputs);
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("outputs moved off clock");

	property p_reg_capture;
		ctrl_r.reg_mode && master_clk && !mclk_d_r |=> in_cap_r == $past(switch_inputs);
	endproperty
	a_reg_capture: assert property (p_reg_capture) else $error("inputs not captured");

	property p_load;
		pop && !cmd_out.commit |=> hold_r[$past(cmd_out.chan)]
			== {$past(cmd_out.flt), $past(cmd_out.dest)};
	endproperty
	a_load: assert property (p_load) else $error("holding latch not loaded");

	property p_commit;
		pop && cmd_out.commit |=> ctl_r[5] == $past(hold_r[5]) && ctl_r[63] == $past(hold_r[63]);
	endproperty
	a_commit: assert property (p_commit) else $error("commit not applied");

	property p_mon_off;
		!ctrl_r.mon_en |=> monitor_bus == 7'h00 && !monitor_path_out;
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor not released");

	property p_mon_word;
		ctrl_r.mon_en && !ctrl_r.reg_mode |=> monitor_bus == $past(ctl_r[ctrl_r.mon_sel]);
	endproperty
	a_mon_word: assert property (p_mon_word) else $error("monitor word wrong");

	property p_mon_path;
		ctrl_r.mon_en && !ctrl_r.reg_mode
			|=> monitor_path_out == $past(switch_inputs[ctl_r[ctrl_r.mon_sel].src]);
	endproperty
	a_mon_path: assert property (p_mon_path) else $error("monitor path wrong");

	property p_bresp_after;
		wr_go |=> s_axi_bvalid ##0 (s_axi_awready && s_axi_wready);
	endproperty
	a_bresp_after: assert property (p_bresp_after) else $error("write answer missing");

	c_commit: cover property (pop && cmd_out.commit);
	c_fifo_full: cover property (!fifo_in_ready ##1 fifo_in_ready);
	c_reg_monitor: cover property (ctrl_r.reg_mode && ctrl_r.mon_en && mclk_rise);

endmodule : xps_crosspoint

// >>> core/xps_pkg.sv
// Shared constants and types for the 64x64 crosspoint switch core.
// Assumes a single 25 MHz core clock and an AXI4-Lite register port.
package xps_pkg;

	localparam int N_PORTS = 64;
	localparam int SEL_W = 6;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOAD = 8'h04;
	localparam logic [7:0] OFS_COMMIT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// CTRL fields
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_MON_EN_BIT = 1;
	localparam int CTRL_PAUSE_BIT = 2;
	localparam int CTRL_MON_SEL_LSB = 8;
	// LOAD fields
	localparam int LOAD_CHAN_LSB = 0;
	localparam int LOAD_DEST_LSB = 8;
	localparam int LOAD_FLOAT_BIT = 16;
	// STATUS fields
	localparam int STAT_EMPTY_BIT = 0;
	localparam int STAT_FULL_BIT = 1;
	localparam int STAT_LEVEL_LSB = 8;
	localparam int STAT_MON_LSB = 16;
	localparam int STAT_PATH_BIT = 24;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int CORE_PERIOD_NS = 40;
	localparam int MON_RELEASE_NS = 10;
	localparam int MON_RELEASE_CYC_RAW = MON_RELEASE_NS / CORE_PERIOD_NS;
	localparam int MON_RELEASE_CYC = (MON_RELEASE_CYC_RAW < 1) ? 1 : MON_RELEASE_CYC_RAW;
	localparam int MCLK_MAX_MHZ = 200;
	localparam int DRAIN_DIV_DEF = 4;
	localparam int CMD_FIFO_DEPTH = 8;

	// Stored control word: float on top, source number below
	typedef struct packed {
		logic flt;
		logic [SEL_W-1:0] src;
	} xps_ctl_t;

	// Programming command queued from the register port
	typedef struct packed {
		logic commit;
		logic flt;
		logic [SEL_W-1:0] dest;
		logic [SEL_W-1:0] chan;
	} xps_cmd_t;

	typedef struct packed {
		logic pause;
		logic [SEL_W-1:0] mon_sel;
		logic mon_en;
		logic reg_mode;
	} xps_ctrl_t;

	localparam xps_ctrl_t CTRL_RESET = '{pause: 1'b0, mon_sel: 6'h00, mon_en: 1'b0,
		reg_mode: 1'b0};

endpackage : xps_pkg

// >>> core/xps_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset already synchronised.
module xps_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("xps_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr_r;
	logic [AW:0] rptr_r;
	logic push;
	logic pop;

	assign level = wptr_r - rptr_r;
	assign in_ready = (level != (AW + 1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data = mem[rptr_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end

endmodule : xps_fifo

// >>> verification/xps_data_src.sv
// Far-side model: drives the switch inputs and the master clock pin.
// Assumes the bench asks for one master clock pulse at a time.
module xps_data_src (
	input wire logic core_clk,
	input wire logic [63:0] pattern,
	input wire logic pulse_req,
	output logic [63:0] switch_inputs,
	output logic master_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_r = 3'h0;
	// Two core cycles high per pulse, low between pulses
	always_ff @(posedge core_clk) begin
		if (pulse_req) begin
			cnt_r <= 3'h4;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
	assign master_clk = (cnt_r > 3'h2);
	always_ff @(posedge core_clk) begin
		switch_inputs <= pattern;
	end
endmodule : xps_data_src

// >>> verification/testbench.sv
// Self-checking bench for the crosspoint core over its register port.
// Assumes the far-side model for data and master clock, drain divider 1.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_b, pulse_req, master_clk;
	logic [63:0] pattern, sw_in, sw_out, sw_oe, flt_m, flt_h;
	logic [6:0] mon_bus;
	logic mon_path, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [5:0] src_m[64];
	logic [5:0] src_h[64];
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	localparam logic [63:0] P_A = 64'hF0E1_D2C3_B4A5_9687;
	localparam logic [63:0] P_B = 64'h0F1E_2D3C_4B5A_6978;

	xps_data_src xps_data_src_inst (.core_clk(core_clk), .pattern(pattern),
		.pulse_req(pulse_req), .switch_inputs(sw_in), .master_clk(master_clk));
	xps_crosspoint #(.DRAIN_DIV(1), .FIFO_DEPTH(8)) xps_crosspoint_inst (
		.core_clk(core_clk), .rst_b(rst_b), .master_clk(master_clk),
		.switch_inputs(sw_in), .switch_outputs(sw_out), .switch_outputs_oe(sw_oe),
		.monitor_bus(mon_bus), .monitor_path_out(mon_path),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er, "bresp");
		@(posedge core_clk);
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		chk(rresp, er, "rresp");
		@(posedge core_clk);
	endtask : axr

	task automatic ctl_w(input logic [5:0] sel, input logic [2:0] bits);
		axw(xps_pkg::OFS_CTRL, {18'h0, sel, 5'h0, bits}, xps_pkg::RESP_OKAY);
	endtask : ctl_w

	task automatic load(input logic [5:0] ch, input logic [5:0] s, input logic f);
		axw(xps_pkg::OFS_LOAD, {15'h0, f, 2'h0, s, 2'h0, ch}, xps_pkg::RESP_OKAY);
		src_h[ch] = s;
		flt_h[ch] = f;
	endtask : load

	// Commit, then wait until the queue has emptied and outputs settled
	task automatic commit_all();
		logic [31:0] d;
		axw(xps_pkg::OFS_COMMIT, 32'h0, xps_pkg::RESP_OKAY);
		src_m = src_h;
		flt_m = flt_h;
		do axr(xps_pkg::OFS_STATUS, d, xps_pkg::RESP_OKAY);
		while (d[0] !== 1'b1);
		repeat (3) @(posedge core_clk);
	endtask : commit_all

	task automatic chk_route(input logic [63:0] p);
		logic [63:0] e;
		for (int i = 0; i < 64; i++) e[i] = p[src_m[i]];
		chk(sw_oe, ~flt_m, "enables");
		chk(sw_out & ~flt_m, e & ~flt_m, "routing");
	endtask : chk_route

	task automatic set_pat(input logic [63:0] p);
		pattern <= p;
		repeat (3) @(posedge core_clk);
	endtask : set_pat

	task automatic mpulse();
		pulse_req <= 1'b1;
		@(posedge core_clk);
		pulse_req <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask : mpulse

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] d;
		axr(xps_pkg::OFS_CTRL, d, xps_pkg::RESP_OKAY);
		chk(d, 0, "ctrl reset");
		axr(xps_pkg::OFS_STATUS, d, xps_pkg::RESP_OKAY);
		chk(d, 32'h1, "status reset");
		axr(8'h10, d, xps_pkg::RESP_SLVERR);
		chk(d, 0, "unmapped read");
		axw(8'h14, 32'h0, xps_pkg::RESP_SLVERR);
		axr(xps_pkg::OFS_LOAD, d, xps_pkg::RESP_OKAY);
		chk(d, 0, "load readback");
	endtask : t_regs

	// Every output programmed once, upper quarter broadcast from one input
	task automatic t_prog();
		for (int i = 0; i < 64; i++) load(6'(i), 6'(i < 48 ? (i * 5 + 3) % 64 : 7), i % 9 == 4);
		commit_all();
		set_pat(P_A);
		chk_route(P_A);
		set_pat(P_B);
		chk_route(P_B);
	endtask : t_prog

	task automatic t_dbuf();
		load(6'h00, 6'h3C, 1'b0);
		repeat (6) @(posedge core_clk);
		chk_route(P_B);
		commit_all();
		chk_route(P_B);
	endtask : t_dbuf

	task automatic t_mon(input logic [5:0] sel);
		ctl_w(sel, 3'h2);
		repeat (2) @(posedge core_clk);
		chk(mon_bus, {flt_m[sel], src_m[sel]}, "monitor bus");
		chk(mon_path, P_B[src_m[sel]], "monitor path");
		ctl_w(sel, 3'h0);
		chk(mon_bus, 0, "monitor off");
		chk(mon_path, 0, "path off");
	endtask : t_mon

	task automatic t_regmode();
		set_pat(P_A);
		ctl_w(6'h00, 3'h1);
		mpulse();
		mpulse();
		chk_route(P_A);
		set_pat(P_B);
		chk_route(P_A);
		mpulse();
		chk_route(P_A);
		mpulse();
		chk_route(P_B);
		ctl_w(6'h00, 3'h0);
		set_pat(P_A);
		chk_route(P_A);
	endtask : t_regmode

	// Queue filled while paused, then drained in write order
	task automatic t_fifo();
		logic [31:0] d;
		ctl_w(6'h00, 3'h4);
		for (int k = 0; k < 8; k++) load(6'h01, 6'(10 + k), 1'b0);
		axr(xps_pkg::OFS_STATUS, d, xps_pkg::RESP_OKAY);
		chk(d[11:0], 12'h802, "queue full");
		ctl_w(6'h00, 3'h0);
		commit_all();
		chk_route(P_A);
	endtask : t_fifo

	////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	initial begin
		rst_b = 1'b0;
		pulse_req = 1'b0;
		pattern = 64'h0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_regs();
		t_prog();
		t_dbuf();
		t_mon(6'h04);
		t_mon(6'h32);
		t_regmode();
		t_fifo();
		finish_test();
	end
endmodule : testbench
